// >>> scc_pkg.sv
// Shared constants, code tables and carrier types for the special character codec.
package scc_pkg;

  // ----------------------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------------------
  localparam int SCC_BYTE_W = 8;
  localparam int SCC_SYM_W = 10;
  localparam int SCC_NUM_K = 12;
  localparam int SCC_FIFO_DEPTH = 32;
  localparam logic [3:0] SCC_LAST_BIT = 4'h9;
  localparam logic [3:0] SCC_BALANCED_ONES = 4'h5;
  localparam logic [6:0] SCC_COMMA_NEG = 7'h1F;
  localparam logic [6:0] SCC_COMMA_POS = 7'h60;
  localparam logic [3:0] SCC_IDLE_IDX = 4'h5;

  // ----------------------------------------------------------------------------
  // Control byte values, HGF EDCBA
  // ----------------------------------------------------------------------------
  localparam logic [7:0] SCC_K_BYTE [SCC_NUM_K] = '{
    8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC,
    8'hDC, 8'hFC, 8'hF7, 8'hFB, 8'hFD, 8'hFE
  };

  // ----------------------------------------------------------------------------
  // Code groups abcdei fghj, bit a is the MSB
  // ----------------------------------------------------------------------------
  localparam logic [9:0] SCC_K_NEG [SCC_NUM_K] = '{
    10'h0F4, // (RULE4)
    10'h0F9, // (RULE2)
    10'h0F5, // (RULE5)
    10'h0F3, // (RULE5)
    10'h0F2, // (RULE5)
    10'h0FA, // (RULE1)
    10'h0F6, // (RULE6)
    10'h0F8, // (RULE3)
    10'h3A8, // (RULE7)
    10'h368, // (RULE7)
    10'h2E8, // (RULE8)
    10'h1E8  // (RULE8)
  };
  localparam logic [9:0] SCC_K_POS [SCC_NUM_K] = '{
    10'h30B, // (RULE4)
    10'h306, // (RULE2)
    10'h30A, // (RULE5)
    10'h30C, // (RULE5)
    10'h30D, // (RULE5)
    10'h305, // (RULE1)
    10'h309, // (RULE6)
    10'h307, // (RULE3)
    10'h057, // (RULE7)
    10'h097, // (RULE7)
    10'h117, // (RULE8)
    10'h217  // (RULE8)
  };

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef enum logic [0:0] {
    SCC_RX_HUNT = 1'b0,
    SCC_RX_LOCKED = 1'b1
  } scc_rx_state_t;

  typedef struct packed {
    logic [7:0] ctrl_byte;
  } scc_tx_req_t;

  typedef struct packed {
    logic [7:0] ctrl_byte;
    logic [9:0] symbol;
    logic idle;
    logic invalid;
    logic disp_err;
  } scc_rx_char_t;

endpackage : scc_pkg

// >>> scc_fifo.sv
// Request FIFO with a registered read port for the special character codec.
`timescale 1ns/1ps
module scc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } scc_fifo_state_t;

  scc_fifo_state_t q;
  scc_fifo_state_t d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop_mem;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  // The output register counts as storage, so the FIFO holds DEPTH plus one words.
  always_comb begin
    d = q;
    push = wr_valid_in && (q.count != (AW+1)'(DEPTH));
    pop_mem = (q.count != '0) && (!q.out_valid || rd_ready_in);
    if (push) begin
      d.wr_ptr = q.wr_ptr + 1'b1;
    end
    if (pop_mem) begin
      d.rd_ptr = q.rd_ptr + 1'b1;
      d.out_data = mem[q.rd_ptr];
      d.out_valid = 1'b1;
    end else if (rd_ready_in) begin
      d.out_valid = 1'b0;
    end
    d.count = q.count + (AW+1)'(push) - (AW+1)'(pop_mem);
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[q.wr_ptr] <= wr_data_in;
    end
  end

  assign wr_ready_out = (q.count != (AW+1)'(DEPTH));
  assign rd_data_out = q.out_data;
  assign rd_valid_out = q.out_valid;

endmodule : scc_fifo

// >>> scc_codec.sv
// Special character encoder, receive aligner and decoder with disparity tracking.
`timescale 1ns/1ps

// What this block does
// (RULE1) K28.5 encodes per running disparity column.
// (RULE2) K28.1 encodes per running disparity column.
// (RULE3) K28.7 encodes per running disparity column.
// (RULE4) K28.0 encodes per running disparity column.
// (RULE5) K28.2, K28.3, K28.4 encode per column.
// (RULE6) K28.6 encodes per running disparity column.
// (RULE7) K23.7 and K27.7 encode per column.
// (RULE8) K29.7 and K30.7 encode per column.
// (RULE9) Only twelve control codes valid; others flagged.
// (RULE10) Running disparity sign selects the code column.
// (RULE11) Receiver aligns character boundaries on idle commas.
// (RULE12) One byte maps to one ten-bit group.
// (RULE13) Reset disparity negative; unbalanced groups invert it.
module scc_codec (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire scc_pkg::scc_tx_req_t tx_req_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic [9:0] tx_sym_out,
  output logic tx_sym_valid_out,
  input wire logic tx_sym_ready_in,
  output logic tx_invalid_out,
  output logic tx_rd_pos_out,
  input wire logic rx_bit_in,
  input wire logic rx_bit_valid_in,
  output scc_pkg::scc_rx_char_t rx_char_out,
  output logic rx_char_valid_out,
  output logic rx_aligned_out,
  output logic rx_rd_pos_out
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic tx_rd_pos;
    logic [9:0] tx_sym;
    logic tx_vld;
    logic tx_invalid;
    logic [9:0] rx_shift;
    logic [3:0] rx_cnt;
    scc_pkg::scc_rx_state_t rx_state;
    logic rx_rd_pos;
    scc_pkg::scc_rx_char_t rx_char;
    logic rx_vld;
  } scc_state_t;

  scc_state_t q;
  scc_state_t d;
  scc_pkg::scc_tx_req_t fifo_data;
  logic fifo_valid;
  logic fifo_pop;

  // ----------------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------------
  // A group with other than five ones leaves the line unbalanced.
  function automatic logic scc_unbalanced(input logic [9:0] sym);
    logic [3:0] ones;
    ones = 4'h0;
    for (int i = 0; i < 10; i++) begin
      ones = ones + 4'(sym[i]);
    end
    return ones != scc_pkg::SCC_BALANCED_ONES; // (RULE13)
  endfunction : scc_unbalanced

  // Returns {found, index} for a control byte.
  function automatic logic [4:0] scc_find_byte(input logic [7:0] b);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < scc_pkg::SCC_NUM_K; i++) begin
      if (scc_pkg::SCC_K_BYTE[i] == b) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r; // (RULE9)
  endfunction : scc_find_byte

  // Returns {found, positive column, index} for a received group.
  function automatic logic [5:0] scc_find_sym(input logic [9:0] s);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < scc_pkg::SCC_NUM_K; i++) begin
      if (scc_pkg::SCC_K_NEG[i] == s) begin
        r = {2'b10, 4'(i)};
      end
      if (scc_pkg::SCC_K_POS[i] == s) begin
        r = {2'b11, 4'(i)};
      end
    end
    return r; // (RULE9)
  endfunction : scc_find_sym

  function automatic logic [9:0] scc_pick(input logic [3:0] idx, input logic rd_pos);
    logic [9:0] r;
    r = rd_pos ? scc_pkg::SCC_K_POS[idx] : scc_pkg::SCC_K_NEG[idx]; // (RULE10)
    return r;
  endfunction : scc_pick

  // ----------------------------------------------------------------------------
  // Request buffer
  // ----------------------------------------------------------------------------
  // When the link stalls, requests back up here until tx_ready_out drops.
  scc_fifo #(
    .WIDTH(scc_pkg::SCC_BYTE_W),
    .DEPTH(scc_pkg::SCC_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .wr_data_in(tx_req_in),
    .wr_valid_in(tx_valid_in),
    .wr_ready_out(tx_ready_out),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_pop)
  );

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    logic load;
    logic [4:0] hit;
    logic [3:0] idx;
    logic [9:0] code;
    logic [9:0] sh;
    logic [5:0] found;
    logic comma;
    logic boundary;
    load = 1'b0;
    hit = 5'h00;
    idx = scc_pkg::SCC_IDLE_IDX;
    code = 10'h000;
    sh = 10'h000;
    found = 6'h00;
    comma = 1'b0;
    boundary = 1'b0;
    d = q;
    d.tx_invalid = 1'b0;
    d.rx_vld = 1'b0;
    fifo_pop = 1'b0;

    // Transmit: one request byte becomes one ten-bit group.
    load = !q.tx_vld || tx_sym_ready_in;
    if (load) begin
      if (fifo_valid) begin
        fifo_pop = 1'b1;
        hit = scc_find_byte(fifo_data.ctrl_byte);
        if (hit[4]) begin
          idx = hit[3:0]; // (RULE12)
        end else begin
          d.tx_invalid = 1'b1; // (RULE9)
        end
      end
      // An empty queue or a rejected byte sends an idle, keeping the receiver aligned.
      code = scc_pick(idx, q.tx_rd_pos); // (RULE10)
      d.tx_sym = code;
      d.tx_vld = 1'b1;
      d.tx_rd_pos = q.tx_rd_pos ^ scc_unbalanced(code); // (RULE13)
    end

    // Receive: first bit on the line is bit a, so it ends up in the MSB.
    if (rx_bit_valid_in) begin
      sh = {q.rx_shift[8:0], rx_bit_in};
      d.rx_shift = sh;
      comma = (sh[9:3] == scc_pkg::SCC_COMMA_NEG) || (sh[9:3] == scc_pkg::SCC_COMMA_POS);
      case (q.rx_state)
        scc_pkg::SCC_RX_HUNT: begin
          boundary = comma; // (RULE11)
        end
        scc_pkg::SCC_RX_LOCKED: begin
          boundary = comma || (q.rx_cnt == scc_pkg::SCC_LAST_BIT); // (RULE11)
        end
        default: begin
          boundary = 1'b0;
        end
      endcase
      if (boundary) begin
        d.rx_state = scc_pkg::SCC_RX_LOCKED;
        d.rx_cnt = 4'h0;
        found = scc_find_sym(sh);
        d.rx_vld = 1'b1;
        d.rx_char.symbol = sh; // (RULE12)
        d.rx_char.ctrl_byte = found[5] ? scc_pkg::SCC_K_BYTE[found[3:0]] : 8'h00;
        d.rx_char.invalid = !found[5]; // (RULE9)
        d.rx_char.idle = found[5] && (found[3:0] == scc_pkg::SCC_IDLE_IDX);
        d.rx_char.disp_err = found[5] && (found[4] != q.rx_rd_pos); // (RULE10)
        d.rx_rd_pos = q.rx_rd_pos ^ scc_unbalanced(sh); // (RULE13)
      end else begin
        d.rx_cnt = q.rx_cnt + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  // Both disparity flags reset to zero, which means negative.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0; // (RULE13)
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign tx_sym_out = q.tx_sym;
  assign tx_sym_valid_out = q.tx_vld;
  assign tx_invalid_out = q.tx_invalid;
  assign tx_rd_pos_out = q.tx_rd_pos;
  assign rx_char_out = q.rx_char;
  assign rx_char_valid_out = q.rx_vld;
  assign rx_aligned_out = (q.rx_state == scc_pkg::SCC_RX_LOCKED);
  assign rx_rd_pos_out = q.rx_rd_pos;

endmodule : scc_codec

// >>> scc_codec_chk.sv
// Concurrent checker for the special character codec ports.
`timescale 1ns/1ps
module scc_codec_chk (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [9:0] tx_sym_out,
  input wire logic tx_sym_valid_out,
  input wire logic tx_sym_ready_in,
  input wire logic tx_invalid_out,
  input wire logic tx_rd_pos_out,
  input wire scc_pkg::scc_rx_char_t rx_char_out,
  input wire logic rx_char_valid_out,
  input wire logic rx_aligned_out
);
  // ------
  // Assertions
  // ------
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  AST_FIRST_IDLE: assert property ($rose(tx_sym_valid_out) |->
    tx_sym_out == 10'h0FA && tx_rd_pos_out) else $error("First group not idle at negative");
  AST_HEAVY_POS: assert property (tx_sym_valid_out && $countones(tx_sym_out) > 5 |->
    tx_rd_pos_out) else $error("Heavy group without positive disparity");
  AST_LIGHT_NEG: assert property (tx_sym_valid_out && $countones(tx_sym_out) < 5 |->
    !tx_rd_pos_out) else $error("Light group without negative disparity");
  AST_COLUMN: assert property (tx_sym_valid_out && tx_sym_ready_in |=>
    ($past(tx_rd_pos_out) ? (tx_sym_out inside {scc_pkg::SCC_K_POS})
      : (tx_sym_out inside {scc_pkg::SCC_K_NEG}))) else $error("Wrong code column");
  AST_STALL_HOLD: assert property (tx_sym_valid_out && !tx_sym_ready_in |=>
    $stable(tx_sym_out)) else $error("Group changed while stalled");
  AST_KCODE: assert property (tx_sym_valid_out |->
    tx_sym_out inside {scc_pkg::SCC_K_NEG, scc_pkg::SCC_K_POS}) else $error("Group not a control code");
  AST_INV_IDLE: assert property (tx_invalid_out |->
    tx_sym_out inside {10'h0FA, 10'h305}) else $error("Invalid byte not replaced by idle");
  AST_RX_ALIGN: assert property (rx_char_valid_out |-> rx_aligned_out)
    else $error("Character before alignment");
  AST_RX_PULSE: assert property (rx_char_valid_out |=> !rx_char_valid_out)
    else $error("Two characters on adjacent cycles");
  AST_RX_IDLE: assert property (rx_char_valid_out && rx_char_out.idle |->
    rx_char_out.ctrl_byte == 8'hBC) else $error("Idle flag on a non idle byte");
endmodule : scc_codec_chk
bind scc_codec scc_codec_chk u_chk (.clk_sys_in, .resetn_in, .tx_sym_out, .tx_sym_valid_out,
  .tx_sym_ready_in, .tx_invalid_out, .tx_rd_pos_out, .rx_char_out, .rx_char_valid_out,
  .rx_aligned_out);

// >>> scc_link_model.sv
// Link partner model that serialises accepted groups back to the receiver.
`timescale 1ns/1ps
module scc_link_model (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [9:0] sym_in,
  input wire logic sym_valid_in,
  output logic sym_ready_out,
  output logic bit_out,
  output logic bit_valid_out,
  input wire logic stall_in,
  input wire logic inj_in,
  input wire logic [9:0] inj_sym_in
);
  logic [9:0] sh_q;
  logic [3:0] cnt_q;
  // Ready never looks at valid, so no loop forms through the encoder.
  assign sym_ready_out = (cnt_q == 4'h0) && !stall_in && !inj_in;
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sh_q <= 10'h000;
      cnt_q <= 4'h0;
      bit_out <= 1'b0;
      bit_valid_out <= 1'b0;
    end else begin
      bit_valid_out <= (cnt_q != 4'h0);
      // An idle line toggles so a stale bit is never mistaken for data.
      bit_out <= (cnt_q != 4'h0) ? sh_q[9] : !bit_out;
      if (cnt_q != 4'h0) begin
        sh_q <= {sh_q[8:0], 1'b0};
        cnt_q <= cnt_q - 4'h1;
      end else if (inj_in) begin
        sh_q <= inj_sym_in;
        cnt_q <= 4'hA;
      end else if (sym_ready_out && sym_valid_in) begin
        sh_q <= sym_in;
        cnt_q <= 4'hA;
      end
    end
  end
endmodule : scc_link_model

// >>> tb_special_char_8b10b_codec.sv
// Testbench looping the encoder through the link model into the receiver.
`timescale 1ns/1ps
module tb_special_char_8b10b_codec;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  scc_pkg::scc_tx_req_t tx_req_in = '0;
  logic tx_valid_in = 1'b0;
  logic stall = 1'b1;
  logic inj = 1'b0;
  logic [9:0] inj_sym = 10'h2AA;
  logic tx_ready_out, tx_sym_valid_out, tx_sym_ready_in, tx_invalid_out, tx_rd_pos_out;
  logic rx_bit_in, rx_bit_valid_in, rx_char_valid_out, rx_aligned_out, rx_rd_pos_out;
  logic [9:0] tx_sym_out;
  logic [9:0] want;
  scc_pkg::scc_rx_char_t rx_char_out;
  logic exp_rd = 1'b0;
  logic exp_rx_rd = 1'b0;
  logic pos_col;
  int n_mismatch = 0, tests_run = 0, cycles = 0, n_inv = 0, n_tx = 0, n_rx = 0, k, n;
  int q[$];
  scc_codec dut (.clk_sys_in, .resetn_in, .tx_req_in, .tx_valid_in, .tx_ready_out, .tx_sym_out,
    .tx_sym_valid_out, .tx_sym_ready_in, .tx_invalid_out, .tx_rd_pos_out, .rx_bit_in,
    .rx_bit_valid_in, .rx_char_out, .rx_char_valid_out, .rx_aligned_out, .rx_rd_pos_out);
  scc_link_model u_link (.clk_sys_in, .resetn_in, .sym_in(tx_sym_out),
    .sym_valid_in(tx_sym_valid_out), .sym_ready_out(tx_sym_ready_in), .bit_out(rx_bit_in),
    .bit_valid_out(rx_bit_valid_in), .stall_in(stall), .inj_in(inj), .inj_sym_in(inj_sym));
  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // ------
  // Helpers
  // ------
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic int kidx(input logic [9:0] s);
    for (int i = 0; i < scc_pkg::SCC_NUM_K; i++) begin
      if (s === scc_pkg::SCC_K_NEG[i] || s === scc_pkg::SCC_K_POS[i]) return i;
    end
    return -1;
  endfunction : kidx
  task automatic wrap_up();
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic push(input logic [7:0] b, input int i);
    tx_req_in.ctrl_byte <= b;
    tx_valid_in <= 1'b1;
    do @(posedge clk_sys_in); while (tx_ready_out !== 1'b1);
    if (i >= 0) q.push_back(i);
  endtask : push
  task automatic drain();
    for (int c = 0; c < 3000 && q.size() != 0; c++) @(posedge clk_sys_in);
    check("tx_left", 10'h000, 10'(q.size()));
  endtask : drain
  // ------
  // Monitors
  // ------
  always @(posedge clk_sys_in) begin
    cycles++;
    if (resetn_in && tx_invalid_out === 1'b1) n_inv++;
    if (resetn_in && tx_sym_valid_out && tx_sym_ready_in) begin
      n_tx++;
      want = (q.size() > 0) ?
        (exp_rd ? scc_pkg::SCC_K_POS[q[0]] : scc_pkg::SCC_K_NEG[q[0]]) : 10'h000;
      if (q.size() > 0 && tx_sym_out === want) void'(q.pop_front());
      else check("tx_group", exp_rd ? 10'h305 : 10'h0FA, tx_sym_out);
      exp_rd = exp_rd ^ ($countones(tx_sym_out) != 5);
    end
    if (resetn_in && rx_char_valid_out === 1'b1) begin
      n_rx++;
      k = kidx(rx_char_out.symbol);
      pos_col = (k >= 0) ? (rx_char_out.symbol === scc_pkg::SCC_K_POS[k]) : 1'b0;
      check("rx_byte", {2'b00, k < 0 ? 8'h00 : scc_pkg::SCC_K_BYTE[k]},
        {2'b00, rx_char_out.ctrl_byte});
      check("rx_flags", {7'h00, k < 0, k == 5, k >= 0 && pos_col != exp_rx_rd},
        {7'h00, rx_char_out.invalid, rx_char_out.idle, rx_char_out.disp_err});
      exp_rx_rd = exp_rx_rd ^ ($countones(rx_char_out.symbol) != 5);
      check("rx_rd_pos", {9'h000, exp_rx_rd}, {9'h000, rx_rd_pos_out});
    end
    if (cycles > 8000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // ------
  // Scenarios
  // ------
  task automatic t_reset_idle();
    repeat (2) @(posedge clk_sys_in);
    check("idle_after_reset", 10'h0FA, tx_sym_out);
    check("rd_after_reset", 10'h001, {9'h000, tx_rd_pos_out});
  endtask : t_reset_idle
  task automatic t_codes();
    stall <= 1'b0;
    for (int i = 0; i < scc_pkg::SCC_NUM_K; i++) begin
      if (i == 6) push(8'h00, -1);
      push(scc_pkg::SCC_K_BYTE[i], i);
    end
    tx_valid_in <= 1'b0;
    drain();
    check("tx_invalid_pulses", 10'h001, 10'(n_inv));
  endtask : t_codes
  task automatic t_fifo();
    stall <= 1'b1;
    repeat (15) @(posedge clk_sys_in);
    n = 0;
    tx_req_in.ctrl_byte <= 8'h3C;
    tx_valid_in <= 1'b1;
    repeat (40) begin
      @(posedge clk_sys_in);
      if (tx_ready_out === 1'b1) begin
        n++;
        q.push_back(1);
      end
    end
    tx_valid_in <= 1'b0;
    check("fifo_depth", 10'(scc_pkg::SCC_FIFO_DEPTH + 1), 10'(n));
    stall <= 1'b0;
    drain();
  endtask : t_fifo
  task automatic t_inject();
    stall <= 1'b1;
    repeat (15) @(posedge clk_sys_in);
    // A balanced data group, then one idle twice against the line disparity.
    // The first idle is flagged and the second brings the receiver back in step.
    for (int j = 0; j < 3; j++) begin
      inj_sym <= (j == 0) ? 10'h2AA : (exp_rd ? scc_pkg::SCC_K_NEG[5] : scc_pkg::SCC_K_POS[5]);
      inj <= 1'b1;
      @(posedge clk_sys_in);
      inj <= 1'b0;
      repeat (11) @(posedge clk_sys_in);
    end
    stall <= 1'b0;
    repeat (60) @(posedge clk_sys_in);
    stall <= 1'b1;
    repeat (30) @(posedge clk_sys_in);
    check("rx_count", 10'(n_tx + 3), 10'(n_rx));
    check("rx_aligned", 10'h001, {9'h000, rx_aligned_out});
    check("rx_rd_end", {9'h000, exp_rd}, {9'h000, rx_rd_pos_out});
  endtask : t_inject
  initial begin
    repeat (20) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    t_reset_idle();
    t_codes();
    t_fifo();
    t_inject();
    wrap_up();
  end
endmodule : tb_special_char_8b10b_codec
